/* File: core/fssc_controller.sv */
// fail-safe state controller with apb registers, retained latch and interrupt
// Summary of operation
// - inhibit clears on power-on reset only after loss of all three supplies
// - inhibit sets on set command with 0xAA or preregulator overvoltage
// - after reset release, inhibit clears only on clear command with 0x55
// - inhibit and wake arm decide whether OFF restarts automatically while wake stays high
// - inhibit readable both from retained latch and device status register
// - clock fault or overvoltage in INIT holds reset until timeout; only timeout kept
// - clock fault or overvoltage after reset release goes OFF and retains causes
// - timeout shutdown root causes may keep earlier OFF causes as well
// - four operating states and two nonoperating states
// - fault-count shutdown and start-up timeout are OFF causes with own flags
// - RESET left for DIAG or SAFE only once conditions cleared and extension finished; a shutdown cause goes OFF at once
// - diagnostic leave is bit 0 of safety check control
// - diagnostic leave mask is bit 1 and qualifies diagnostic exit
// - shutdown count limit comes from the shutdown limit config register
// - RESET to SAFE does not increment the fault counter
// - RESET conditions win over global SAFE conditions
// - SAFE condition in RESET waits for RESET conditions to clear
// - inhibited restart after OFF entered from RESET, DIAG, ACT or SAFE with wake high needs wake low then high again
`include "fssc_regs.svh"

module fssc_controller
	import fssc_pkg::*;
#(
	parameter int INIT_TO_CYC = `FSSC_INIT_TO_US * `FSSC_CLK_MHZ,
	parameter int RST_EXT_CYC = `FSSC_RST_EXT_US * `FSSC_CLK_MHZ
)(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        supplyLost,
	input  wire logic        wake,
	input  wire logic        clockOk,
	input  wire logic        systemClockFault,
	input  wire logic        supplyOvervoltage,
	input  wire logic        preregOvervoltage,
	input  wire logic        resetCondition,
	input  wire logic        safeCondition,
	input  wire logic        systemResetIn,
	input  wire logic        faultEvent,
	input  wire fssc_apb_req_t apbReq,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output fssc_state_t      state,
	output logic             coreResetN,
	output logic             systemResetOutN,
	output logic             restartInhibit,
	output logic             irq
);

	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	fssc_state_t state_r;
	logic        inhibit_r;
	logic        inhibitStat_r;
	logic        wakeArm_r;
	logic        wakePrev_r;
	logic        coreRstN_r;
	logic        diagLeave_r;
	logic        diagMask_r;
	logic [3:0]  limit_r;
	logic [3:0]  faultCnt_r;
	fssc_cause_t cause_r;
	logic [2:0]  irqStat_r;
	logic [2:0]  irqMask_r;
	logic [31:0] timer_r;
	logic        safePend_r;
	logic        strapDone_r;

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	logic        wrEn;
	logic        rdEn;
	logic        inhSet;
	logic        inhClr;
	logic        wakeClr;
	logic        goOff;
	logic        offEvt;
	logic        safeEvt;
	logic        inhEvt;
	logic        wakeRise;
	logic        clockBad;

	function automatic logic isAddr(input logic [11:0] a, input logic [11:0] b);
		return a == b;
	endfunction

	// access phase completes in one cycle, no wait states
	assign wrEn    = apbReq.psel && apbReq.penable && apbReq.pwrite;
	assign rdEn    = apbReq.psel && !apbReq.pwrite;
	assign inhSet  = wrEn && isAddr(apbReq.paddr, `FSSC_ADDR_CMD)
		&& apbReq.pwdata[15:8] == `FSSC_CMD_INH_SET && apbReq.pwdata[7:0] == `FSSC_KEY_SET;
	assign inhClr  = wrEn && isAddr(apbReq.paddr, `FSSC_ADDR_CMD)
		&& apbReq.pwdata[15:8] == `FSSC_CMD_INH_CLR && apbReq.pwdata[7:0] == `FSSC_KEY_CLR;
	assign wakeClr = wrEn && isAddr(apbReq.paddr, `FSSC_ADDR_CMD)
		&& apbReq.pwdata[15:8] == `FSSC_CMD_WAKE_CLR;
	assign clockBad = systemClockFault || !clockOk;
	assign wakeRise = wake && !wakePrev_r;
	assign inhEvt   = inhSet || preregOvervoltage;

	// ---------------------------------------------------------------
	// restart inhibit latch
	// ---------------------------------------------------------------
	// strap flag: low through reset, high from the first edge after release
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			strapDone_r <= 1'b0;
		else
			strapDone_r <= 1'b1;
	end

	// retained latch has no reset so it survives a core reset; battery loss clears it
	always_ff @(posedge clock) begin
		if (!strapDone_r) begin
			if (supplyLost)
				inhibit_r <= 1'b0;
		end else if (inhEvt) begin
			inhibit_r <= 1'b1;
		end else if (inhClr) begin
			inhibit_r <= 1'b0;
		end
	end

	// status copy follows the retained latch
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			inhibitStat_r <= 1'b0;
		else
			inhibitStat_r <= inhibit_r;
	end

	// ---------------------------------------------------------------
	// wake edge tracking
	// ---------------------------------------------------------------
	// arm cleared when OFF entered from RESET, DIAG, ACT or SAFE inhibited with wake high
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wakePrev_r <= 1'b0;
			wakeArm_r  <= 1'b1;
		end else begin
			wakePrev_r <= wake;
			if (goOff && inhibit_r && wake)
				wakeArm_r <= 1'b0;
			else if (!wake)
				wakeArm_r <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// state machine
	// ---------------------------------------------------------------
	assign goOff = (state_r != ST_OFF && state_r != ST_INIT)
		&& (clockBad || supplyOvervoltage || faultCnt_r >= limit_r || wakeClr);

	// six states, OFF under reset
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r    <= ST_OFF;
			coreRstN_r <= 1'b0;
			timer_r    <= '0;
			safePend_r <= 1'b0;
		end else begin
			case (state_r)
				ST_OFF: begin
					coreRstN_r <= 1'b0;
					timer_r    <= '0;
					// restart with wake high when not inhibited or when wake arm is still set
					if (wake && (!inhibit_r || (wakeArm_r && wakeRise) || wakeArm_r))
						state_r <= ST_INIT;
				end
				ST_INIT: begin
					timer_r <= timer_r + 32'h1;
					if (clockBad || supplyOvervoltage) begin
						coreRstN_r <= 1'b0;
						if (timer_r >= INIT_TO_CYC - 1)
							state_r <= ST_OFF;
					end else begin
						coreRstN_r <= 1'b1;
						timer_r    <= '0;
						state_r    <= ST_RESET;
					end
				end
				ST_RESET: begin
					if (safeCondition)
						safePend_r <= 1'b1;
					if (goOff) begin
						state_r <= ST_OFF;
					end else if (resetCondition || !systemResetIn) begin
						timer_r <= '0;
					end else if (timer_r < RST_EXT_CYC - 1) begin
						timer_r <= timer_r + 32'h1;
					end else begin
						timer_r    <= '0;
						safePend_r <= 1'b0;
						state_r    <= (safePend_r || safeCondition) ? ST_SAFE : ST_DIAG;
					end
				end
				ST_DIAG: begin
					if (goOff)
						state_r <= ST_OFF;
					else if (resetCondition)
						state_r <= ST_RESET;
					else if (safeCondition)
						state_r <= ST_SAFE;
					else if (diagLeave_r && !diagMask_r)
						state_r <= ST_ACT;
				end
				ST_ACT: begin
					if (goOff)
						state_r <= ST_OFF;
					else if (resetCondition)
						state_r <= ST_RESET;
					else if (safeCondition)
						state_r <= ST_SAFE;
				end
				ST_SAFE: begin
					if (goOff)
						state_r <= ST_OFF;
					else if (resetCondition)
						state_r <= ST_RESET;
				end
				default: state_r <= ST_OFF;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// fault counter
	// ---------------------------------------------------------------
	// counts faultEvent pulses outside RESET, saturates at 15, cleared in OFF
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			faultCnt_r <= '0;
		else if (state_r == ST_OFF)
			faultCnt_r <= '0;
		else if (faultEvent && state_r != ST_RESET && faultCnt_r != 4'hF)
			faultCnt_r <= faultCnt_r + 4'h1;
	end

	// ---------------------------------------------------------------
	// retained root causes
	// ---------------------------------------------------------------
	// causes accumulate across shutdowns until cleared by write-one
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cause_r <= '0;
		end else begin
			if (state_r == ST_INIT && clockBad || supplyOvervoltage && state_r == ST_INIT) begin
				if (timer_r >= INIT_TO_CYC - 1)
					cause_r.initTimeout <= 1'b1;
			end else if (goOff) begin
				cause_r.clockFault    <= cause_r.clockFault | clockBad;
				cause_r.overvolt      <= cause_r.overvolt | supplyOvervoltage;
				cause_r.countShutdown <= cause_r.countShutdown
					| (faultCnt_r >= limit_r);
			end else if (wrEn && isAddr(apbReq.paddr, `FSSC_ADDR_ROOT_CAUSE)) begin
				cause_r <= cause_r & ~apbReq.pwdata[3:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// control registers
	// ---------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			diagLeave_r <= 1'b0;
			diagMask_r  <= 1'b0;
			limit_r     <= `FSSC_LIMIT_RST;
			irqMask_r   <= '0;
		end else if (wrEn) begin
			if (isAddr(apbReq.paddr, `FSSC_ADDR_CHECK_CTRL)) begin
				diagLeave_r <= apbReq.pwdata[`FSSC_BIT_DIAG_LEAVE];
				diagMask_r  <= apbReq.pwdata[`FSSC_BIT_DIAG_MASK];
			end
			if (isAddr(apbReq.paddr, `FSSC_ADDR_LIMIT_CFG))
				limit_r <= apbReq.pwdata[3:0];
			if (isAddr(apbReq.paddr, `FSSC_ADDR_IRQ_MASK))
				irqMask_r <= apbReq.pwdata[2:0];
		end
	end

	// ---------------------------------------------------------------
	// interrupt status
	// ---------------------------------------------------------------
	assign offEvt  = goOff;
	assign safeEvt = state_r != ST_SAFE && state_r != ST_OFF && safeCondition;

	// set wins over write-one clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			irqStat_r <= '0;
		else
			irqStat_r <= (irqStat_r & ~((wrEn && isAddr(apbReq.paddr, `FSSC_ADDR_IRQ_STAT))
				? apbReq.pwdata[2:0] : 3'h0))
				| {inhEvt && !inhibit_r, safeEvt, offEvt};
	end

	// ---------------------------------------------------------------
	// apb read path and registered outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= apbReq.psel && !apbReq.penable;
			pslverr <= 1'b0;
			prdata  <= '0;
			if (rdEn && !apbReq.penable) begin
				case (apbReq.paddr)
					`FSSC_ADDR_STATUS:
						prdata <= {28'h0, inhibitStat_r, state_r};
					`FSSC_ADDR_CHECK_CTRL: prdata <= {30'h0, diagMask_r, diagLeave_r};
					`FSSC_ADDR_LIMIT_CFG:  prdata <= {28'h0, limit_r};
					`FSSC_ADDR_ROOT_CAUSE: prdata <= {28'h0, cause_r};
					`FSSC_ADDR_IRQ_STAT:   prdata <= {29'h0, irqStat_r};
					`FSSC_ADDR_IRQ_MASK:   prdata <= {29'h0, irqMask_r};
					`FSSC_ADDR_FAULT_CNT:  prdata <= {28'h0, faultCnt_r};
					`FSSC_ADDR_CMD:        prdata <= '0;
					default:               pslverr <= 1'b1;
				endcase
			end else if (apbReq.psel && !apbReq.penable) begin
				pslverr <= !(isAddr(apbReq.paddr, `FSSC_ADDR_CMD)
					|| isAddr(apbReq.paddr, `FSSC_ADDR_CHECK_CTRL)
					|| isAddr(apbReq.paddr, `FSSC_ADDR_LIMIT_CFG)
					|| isAddr(apbReq.paddr, `FSSC_ADDR_ROOT_CAUSE)
					|| isAddr(apbReq.paddr, `FSSC_ADDR_IRQ_STAT)
					|| isAddr(apbReq.paddr, `FSSC_ADDR_IRQ_MASK));
			end
		end
	end

	// mirrors of internal state for the pins
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state           <= ST_OFF;
			coreResetN      <= 1'b0;
			systemResetOutN <= 1'b0;
			restartInhibit  <= 1'b0;
			irq             <= 1'b0;
		end else begin
			state           <= state_r;
			coreResetN      <= coreRstN_r;
			systemResetOutN <= state_r == ST_DIAG || state_r == ST_ACT || state_r == ST_SAFE;
			restartInhibit  <= inhibit_r;
			irq             <= |(irqStat_r & irqMask_r);
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence seqInhSet;
		inhSet;
	endsequence

	AST_INH_SET: assert property (@(posedge clock) disable iff (rst)
		strapDone_r and seqInhSet |=> inhibit_r)
		else $error("inhibit not set by keyed command");
	AST_INH_CLR: assert property (@(posedge clock) disable iff (rst)
		strapDone_r && $past(strapDone_r) && $fell(inhibit_r) |-> $past(inhClr))
		else $error("inhibit cleared without keyed command");
	AST_INIT_HOLD: assert property (@(posedge clock) disable iff (rst)
		state_r == ST_INIT && (clockBad || supplyOvervoltage) |=> !coreRstN_r)
		else $error("core reset released during clock fault or overvoltage");
	AST_GO_OFF: assert property (@(posedge clock) disable iff (rst)
		goOff |=> state_r == ST_OFF)
		else $error("shutdown cause did not reach OFF");
	AST_DIAGNOSTIC_LEAVE: assert property (@(posedge clock) disable iff (rst)
		$past(state_r) == ST_DIAG && state_r == ST_ACT |-> $past(diagLeave_r) && !$past(diagMask_r))
		else $error("diagnostic exit without unmasked leave request");
	AST_NO_CNT: assert property (@(posedge clock) disable iff (rst)
		state_r == ST_RESET |=> faultCnt_r <= $past(faultCnt_r))
		else $error("fault counter moved in RESET");
	AST_PRIO: assert property (@(posedge clock) disable iff (rst)
		state_r == ST_RESET && resetCondition && !goOff |=> state_r == ST_RESET)
		else $error("left RESET while reset condition active");
	AST_REARM: assert property (@(posedge clock) disable iff (rst)
		state_r == ST_OFF && inhibit_r && !wakeArm_r |=> state_r == ST_OFF)
		else $error("inhibited restart without new wake edge");

endmodule

/* File: core/fssc_regs.svh */
// register offsets, field positions, reset values and timing in microseconds and MHz of the state controller
`ifndef FSSC_REGS_SVH
`define FSSC_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define FSSC_ADDR_STATUS      12'h000
`define FSSC_ADDR_CMD         12'h004
`define FSSC_ADDR_CHECK_CTRL  12'h008
`define FSSC_ADDR_LIMIT_CFG   12'h00C
`define FSSC_ADDR_ROOT_CAUSE  12'h010
`define FSSC_ADDR_IRQ_STAT    12'h014
`define FSSC_ADDR_IRQ_MASK    12'h018
`define FSSC_ADDR_FAULT_CNT   12'h01C

// ---------------------------------------------------------------
// command codes and keys
// ---------------------------------------------------------------
`define FSSC_CMD_INH_SET      8'h01
`define FSSC_CMD_INH_CLR      8'h02
`define FSSC_CMD_WAKE_CLR     8'h03
`define FSSC_KEY_SET          8'hAA
`define FSSC_KEY_CLR          8'h55

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define FSSC_BIT_DIAG_LEAVE   0
`define FSSC_BIT_DIAG_MASK    1
`define FSSC_BIT_INHIBIT      3
`define FSSC_RC_CLOCK         0
`define FSSC_RC_OVERVOLT      1
`define FSSC_RC_COUNT_SHDN    2
`define FSSC_RC_INIT_TO       3
`define FSSC_IRQ_OFF          0
`define FSSC_IRQ_SAFE         1
`define FSSC_IRQ_INHIBIT      2

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define FSSC_LIMIT_RST        4'h7
`define FSSC_INIT_TO_US       1000
`define FSSC_RST_EXT_US       2000
`define FSSC_CLK_MHZ          40

`endif

/* File: core/fssc_pkg.sv */
// types shared by the fail-safe state controller
package fssc_pkg;

	// ---------------------------------------------------------------
	// controller states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF   = 3'h0,
		ST_INIT  = 3'h1,
		ST_RESET = 3'h2,
		ST_DIAG  = 3'h3,
		ST_ACT   = 3'h4,
		ST_SAFE  = 3'h5
	} fssc_state_t;

	// ---------------------------------------------------------------
	// apb request carrier
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} fssc_apb_req_t;

	// ---------------------------------------------------------------
	// retained root causes
	// ---------------------------------------------------------------
	typedef struct packed {
		logic initTimeout;
		logic countShutdown;
		logic overvolt;
		logic clockFault;
	} fssc_cause_t;

endpackage

/* File: verification/fssc_host_model.sv */
// host-side apb master model that issues keyed commands to the state controller
`include "fssc_regs.svh"

module fssc_host_model
	import fssc_pkg::*;
(
	input  wire logic     clock,
	output fssc_apb_req_t apbReq,
	input  wire logic     pready
);
	timeunit 1ns;
	timeprecision 1ps;

	logic hung = 1'b0;

	initial apbReq = '0;

	// ---------------------------------------------------------------
	// bus transfers
	// ---------------------------------------------------------------
	// setup cycle, then access held until pready is seen high or 40 cycles pass
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clock);
		apbReq.penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1) begin
			hung = 1'b1;
		end
		// released lines show inverted values, never the last request
		apbReq <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a, pwdata: ~d};
		@(posedge clock);
	endtask

	// command word: code in bits 15:8, key in bits 7:0
	task automatic cmd(input logic [7:0] code, input logic [7:0] key);
		xfer(1'b1, `FSSC_ADDR_CMD, {16'h0000, code, key});
	endtask

	// leave request in bit 0, leave mask in bit 1
	task automatic leaveCtrl(input logic leave, input logic mask);
		xfer(1'b1, `FSSC_ADDR_CHECK_CTRL, {30'h0, mask, leave});
	endtask
endmodule

/* File: verification/fssc_controller_tb_top.sv */
// self-checking bench for the fail-safe state controller
`include "fssc_regs.svh"

module fssc_controller_tb_top
	import fssc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int T = 20;
	typedef struct {logic err; logic [31:0] e; logic [31:0] m;} fssc_exp_t;

	logic          clock, rst, supplyLost, wake, clockOk, systemClockFault;
	logic          supplyOvervoltage, preregOvervoltage, resetCondition, safeCondition;
	logic          systemResetIn, faultEvent, pready, pslverr;
	logic          coreResetN, systemResetOutN, restartInhibit, irq;
	logic [31:0]   prdata, lfsr;
	fssc_apb_req_t apbReq;
	fssc_state_t   state;
	fssc_exp_t     expQ[$];
	int            fail_count, checks;

	fssc_controller #(.INIT_TO_CYC(T), .RST_EXT_CYC(T)) uut (
		.clock(clock), .rst(rst), .supplyLost(supplyLost), .wake(wake),
		.clockOk(clockOk), .systemClockFault(systemClockFault),
		.supplyOvervoltage(supplyOvervoltage), .preregOvervoltage(preregOvervoltage),
		.resetCondition(resetCondition), .safeCondition(safeCondition),
		.systemResetIn(systemResetIn), .faultEvent(faultEvent), .apbReq(apbReq),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .state(state),
		.coreResetN(coreResetN), .systemResetOutN(systemResetOutN),
		.restartInhibit(restartInhibit), .irq(irq)
	);

	fssc_host_model host (.clock(clock), .apbReq(apbReq), .pready(pready));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] nextRand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic fail(input string msg);
		$display("ERROR t=%0t %s", $time, msg);
		fail_count++;
	endtask

	task automatic final_report();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic cmpPin(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) fail(what);
	endtask

	task automatic cmpRead(input fssc_exp_t x);
		checks++;
		if (pslverr !== x.err || (prdata & x.m) !== x.e) fail($sformatf("read %h", prdata));
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic err);
		expQ.push_back('{err, e, m});
		host.xfer(1'b0, a, 32'h0);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d);
	endtask

	task automatic settle();
		repeat (3) @(posedge clock);
	endtask

	task automatic waitState(input fssc_state_t s, input int lim);
		int n;
		n = 0;
		while (state !== s && n < lim) begin
			@(posedge clock);
			n++;
		end
		checks++;
		if (state !== s) begin
			fail("state wait ran out");
			final_report();
		end
	endtask

	task automatic stay(input fssc_state_t s, input int n);
		repeat (n) begin
			@(posedge clock);
			cmpPin(state, s, "state left early");
		end
	endtask

	task automatic doReset(input logic lost);
		rst <= 1'b1;
		supplyLost <= lost;
		repeat (5) @(posedge clock);
		cmpPin(state, ST_OFF, "state under reset");
		rst <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	task automatic pulseFault();
		faultEvent <= 1'b1;
		@(posedge clock);
		faultEvent <= 1'b0;
		@(posedge clock);
	endtask

	task automatic toggleWake();
		wake <= 1'b0;
		repeat (4) @(posedge clock);
		wake <= 1'b1;
		@(posedge clock);
	endtask

	// ---------------------------------------------------------------
	// read monitor and hang guards
	// ---------------------------------------------------------------
	always @(posedge clock) begin
		if (apbReq.psel && apbReq.penable && pready === 1'b1 && !apbReq.pwrite) begin
			if (expQ.size() == 0) fail("read with no note");
			else cmpRead(expQ.pop_front());
		end
	end

	always @(posedge host.hung) begin
		fail("bus hang");
		final_report();
	end

	initial begin
		repeat (100000) @(posedge clock);
		fail("run too long");
		final_report();
	end

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		{rst, supplyLost, wake, clockOk, systemResetIn, resetCondition, safeCondition} = '1;
		{systemClockFault, supplyOvervoltage, preregOvervoltage, faultEvent} = '0;
		lfsr = 32'h833C;
		fail_count = 0;
		checks = 0;
		// reset versus safe priority
		doReset(1'b1);
		cmpPin(restartInhibit, 1'b0, "inhibit after supply loss");
		waitState(ST_RESET, 200);
		stay(ST_RESET, 3 * T);
		cmpPin(systemResetOutN, 1'b0, "reset out in RESET");
		pulseFault();
		{resetCondition, systemResetIn} <= 2'b00;
		stay(ST_RESET, 2 * T);
		systemResetIn <= 1'b1;
		waitState(ST_SAFE, 4 * T);
		rd(`FSSC_ADDR_FAULT_CNT, 32'h0, 32'hF, 1'b0);
		rd(`FSSC_ADDR_LIMIT_CFG, `FSSC_LIMIT_RST, 32'hF, 1'b0);
		rd(12'hFFC, 32'h0, 32'h0, 1'b1);
		$display("test reset_priority done");
		// diagnostic exit, inhibit keys, interrupt, inhibited restart
		safeCondition <= 1'b0;
		doReset(1'b0);
		waitState(ST_DIAG, 500);
		host.leaveCtrl(1'b1, 1'b1);
		stay(ST_DIAG, 8);
		rd(`FSSC_ADDR_CHECK_CTRL, 32'h3, 32'h3, 1'b0);
		host.leaveCtrl(1'b1, 1'b0);
		waitState(ST_ACT, 10);
		repeat (3) pulseFault();
		rd(`FSSC_ADDR_FAULT_CNT, 32'h3, 32'hF, 1'b0);
		for (int i = 0; i < 4; i++) begin
			lfsr = nextRand(lfsr);
			host.cmd(`FSSC_CMD_INH_SET, (lfsr[7:0] == 8'hAA) ? 8'h00 : lfsr[7:0]);
			settle();
			cmpPin(restartInhibit, 1'b0, "set by wrong key");
		end
		host.cmd(`FSSC_CMD_INH_SET, `FSSC_KEY_SET);
		settle();
		cmpPin(restartInhibit, 1'b1, "inhibit set");
		rd(`FSSC_ADDR_STATUS, {28'h0, 1'b1, ST_ACT}, 32'hF, 1'b0);
		host.cmd(`FSSC_CMD_INH_CLR, `FSSC_KEY_SET);
		settle();
		cmpPin(restartInhibit, 1'b1, "clear by wrong key");
		host.cmd(`FSSC_CMD_INH_CLR, `FSSC_KEY_CLR);
		settle();
		cmpPin(restartInhibit, 1'b0, "inhibit clear");
		host.cmd(`FSSC_CMD_INH_SET, `FSSC_KEY_SET);
		rd(`FSSC_ADDR_IRQ_STAT, 32'h4, 32'h4, 1'b0);
		wr(`FSSC_ADDR_IRQ_MASK, 32'h7);
		settle();
		cmpPin(irq, 1'b1, "irq unmasked");
		wr(`FSSC_ADDR_IRQ_MASK, 32'h0);
		settle();
		cmpPin(irq, 1'b0, "irq masked");
		wr(`FSSC_ADDR_IRQ_MASK, 32'h7);
		wr(`FSSC_ADDR_IRQ_STAT, 32'h7);
		settle();
		cmpPin(irq, 1'b0, "irq after clear");
		rd(`FSSC_ADDR_IRQ_STAT, 32'h0, 32'h7, 1'b0);
		supplyOvervoltage <= 1'b1;
		waitState(ST_OFF, 20);
		supplyOvervoltage <= 1'b0;
		stay(ST_OFF, 8);
		cmpPin(restartInhibit, 1'b1, "latch kept in OFF");
		toggleWake();
		waitState(ST_DIAG, 500);
		rd(`FSSC_ADDR_ROOT_CAUSE, 32'h2, 32'h2, 1'b0);
		$display("test inhibit_restart done");
		// fault-count shutdown, then start-up time-out
		wr(`FSSC_ADDR_ROOT_CAUSE, 32'hF);
		host.cmd(`FSSC_CMD_INH_CLR, `FSSC_KEY_CLR);
		preregOvervoltage <= 1'b1;
		@(posedge clock);
		preregOvervoltage <= 1'b0;
		settle();
		cmpPin(restartInhibit, 1'b1, "overvoltage sets inhibit");
		wr(`FSSC_ADDR_LIMIT_CFG, 32'h2);
		for (int i = 0; i < 4 && state !== ST_OFF; i++) pulseFault();
		waitState(ST_OFF, 20);
		{systemClockFault, clockOk} <= 2'b10;
		toggleWake();
		waitState(ST_INIT, 100);
		cmpPin(coreResetN, 1'b0, "core reset held in INIT");
		waitState(ST_OFF, 4 * T);
		{systemClockFault, clockOk} <= 2'b01;
		toggleWake();
		waitState(ST_DIAG, 500);
		rd(`FSSC_ADDR_ROOT_CAUSE, 32'hC, 32'hF, 1'b0);
		$display("test init_timeout done");
		// wake-latch clear command, then reset without supply loss
		host.cmd(`FSSC_CMD_WAKE_CLR, 8'h00);
		waitState(ST_OFF, 20);
		stay(ST_OFF, 8);
		doReset(1'b0);
		cmpPin(restartInhibit, 1'b1, "inhibit kept over reset");
		$display("test retained_latch done");
		final_report();
	end
endmodule
